// ---- common/cfs_defs.svh ----
// register offsets, field positions, reset values and timing counts of the fault supervisor
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH
`define CFS_OFF_CTRL   12'h000
`define CFS_OFF_STAT   12'h004
`define CFS_OFF_MASK   12'h008
`define CFS_OFF_BUSTO  12'h00c
`define CFS_OFF_TXTO   12'h010
`define CFS_OFF_RXTO   12'h014
`define CFS_OFF_LINES  12'h018
// ctrl fields
`define CFS_CTRL_MODE_LSB 0
`define CFS_CTRL_RELEASE  4
// stat / mask bit positions
`define CFS_ST_DOMCLAMP  0
`define CFS_ST_TXRXSHORT 1
`define CFS_ST_RXCLAMP   2
`define CFS_ST_TXTIMEOUT 3
`define CFS_ST_BUSFAULT  4
`define CFS_ST_OVERTEMP  5
`define CFS_ST_UNDERV    6
`define CFS_ST_TXBLOCK   7
`define CFS_ST_W         8
`define CFS_MASK_RESET   8'h00
// timeout defaults in cycles of pclk
`define CFS_BUSTO_RESET  32'h0000_0fa0
`define CFS_TXTO_RESET   32'h0000_0fa0
`define CFS_RXTO_RESET   32'h0000_0fa0
`endif

// ---- common/cfs_pkg.sv ----
// types of the fault supervisor
package cfs_pkg;
  typedef enum logic [3:0] {
    CFS_MODE_OFF    = 4'b0001,
    CFS_MODE_WAKE   = 4'b0010,
    CFS_MODE_NORMAL = 4'b0100,
    CFS_MODE_RXONLY = 4'b1000
  } cfs_mode_t;
  typedef struct packed {
    logic       bus_dominant;
    logic       tx_dominant;
    logic       rx_dominant;
    logic       overtemp;
    logic       undervoltage;
    logic [5:0] line_fault;
  } cfs_sense_t;
endpackage

// ---- src/cfs_supervisor.sv ----
// fault supervisor of the high speed bus transceiver with apb control
//
// Notes on behaviour
// - long bus dominant flags clamp, forces receive-only
// - clamp shown in status, interrupt low unmasked
// - receive-only holds until software selects normal
// - detect transmit-receive short, report in status
// - short drives interrupt low unless masked
// - short inhibits transmitter until software release
// - overtemperature disables driver, returns keeping mode
// - after cooling wait transmit recessive edge
// - receive stuck recessive during traffic blocks transmitter
// - stuck receive needs software release afterwards
// - detect six bus line short faults
// - line fault sets bus flag, interrupts unmasked
// - line fault leaves operating mode unchanged
// - stabilizer enabled in normal and receive-only
// - undervoltage taken from shared regulator monitors
// - receive-only disables driver, reception stays
// - long transmit dominant stops driving, reports ground short
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "cfs_defs.svh"
module cfs_supervisor #(
  parameter int CNT_W = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire cfs_pkg::cfs_sense_t sense,
  input  wire logic              txd,
  input  wire logic              rxd_in,
  output logic                   rxd,
  output logic                   drv_en,
  output logic                   split_oe_n,
  output logic                   int_n
);
  // ************************************
  // apb registers, fault counters and internal signals
  // ************************************
  cfs_pkg::cfs_mode_t   mode;
  cfs_pkg::cfs_mode_t   next_mode;
  logic [`CFS_ST_W-1:0] stat;
  logic [`CFS_ST_W-1:0] next_stat;
  logic [`CFS_ST_W-1:0] mask;
  logic [`CFS_ST_W-1:0] next_mask;
  logic [`CFS_ST_W-2:0] irq_src;
  logic [CNT_W-1:0]     busto;
  logic [CNT_W-1:0]     txto;
  logic [CNT_W-1:0]     rxto;
  logic [CNT_W-1:0]     next_busto;
  logic [CNT_W-1:0]     next_txto;
  logic [CNT_W-1:0]     next_rxto;
  logic [CNT_W-1:0]     bus_cnt;
  logic [CNT_W-1:0]     tx_cnt;
  logic [CNT_W-1:0]     rx_cnt;
  logic [CNT_W-1:0]     next_bus_cnt;
  logic [CNT_W-1:0]     next_tx_cnt;
  logic [CNT_W-1:0]     next_rx_cnt;
  logic                 ot_wait;
  logic                 next_ot_wait;
  logic                 txd_q;
  logic                 next_txd_q;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 next_rxd;
  logic                 next_drv_en;
  logic                 next_split_oe_n;
  logic                 next_int_n;
  logic                 wr;
  logic                 rd;
  logic                 hit;
  logic                 rel_cmd;
  logic                 txblk;
  logic                 dom_evt;
  logic                 sh_evt;
  logic                 rxc_evt;
  logic                 txo_evt;
  logic                 rxc_now;
  logic                 mode_normal;
  logic                 mode_active;

  assign wr = psel & penable & pwrite & ~pready;
  assign rd = psel & penable & ~pwrite & ~pready;

  always_comb begin
    hit = 1'b0;
    case (paddr)
      `CFS_OFF_CTRL:  hit = 1'b1;
      `CFS_OFF_STAT:  hit = 1'b1;
      `CFS_OFF_MASK:  hit = 1'b1;
      `CFS_OFF_BUSTO: hit = 1'b1;
      `CFS_OFF_TXTO:  hit = 1'b1;
      `CFS_OFF_RXTO:  hit = 1'b1;
      `CFS_OFF_LINES: hit = 1'b1;
      default:        hit = 1'b0;
    endcase
  end
  assign rel_cmd = wr & (paddr == `CFS_OFF_CTRL) & pwdata[`CFS_CTRL_RELEASE];

  // ************************************
  // fault detection
  // ************************************
  assign dom_evt = (busto != '0) && (bus_cnt == busto);
  assign txo_evt = (txto != '0) && (tx_cnt == txto);
  assign sh_evt  = drv_en & txd & ~rxd_in & ~sense.bus_dominant;
  assign rxc_now = sense.bus_dominant & rxd_in;
  assign rxc_evt = (rxto != '0) && (rx_cnt == rxto);
  assign txblk = stat[`CFS_ST_TXRXSHORT] | stat[`CFS_ST_RXCLAMP] | stat[`CFS_ST_TXTIMEOUT] | ot_wait;

  always_comb begin
    next_bus_cnt = sense.bus_dominant ? ((bus_cnt == busto) ? bus_cnt : bus_cnt + 1'b1) : '0;
    next_tx_cnt  = ~txd ? ((tx_cnt == txto) ? tx_cnt : tx_cnt + 1'b1) : '0;
    next_rx_cnt  = rxc_now ? ((rx_cnt == rxto) ? rx_cnt : rx_cnt + 1'b1) : '0;
    next_txd_q = txd;
    next_ot_wait = ot_wait;
    if (sense.overtemp) begin
      next_ot_wait = 1'b1;
    end else if (ot_wait & ~txd_q & txd) begin
      next_ot_wait = 1'b0;
    end
  end

  // ************************************
  // mode, status and bus slave
  // ************************************
  always_comb begin
    next_mode = mode;
    next_mask = mask;
    next_busto = busto;
    next_txto = txto;
    next_rxto = rxto;
    next_stat = stat;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (wr) begin
      case (paddr)
        `CFS_OFF_CTRL: begin
          if (pwdata[3:0] == cfs_pkg::CFS_MODE_OFF || pwdata[3:0] == cfs_pkg::CFS_MODE_WAKE ||
              pwdata[3:0] == cfs_pkg::CFS_MODE_NORMAL || pwdata[3:0] == cfs_pkg::CFS_MODE_RXONLY) begin
            next_mode = cfs_pkg::cfs_mode_t'(pwdata[3:0]);
          end
        end
        `CFS_OFF_STAT:  next_stat = stat & ~pwdata[`CFS_ST_W-1:0];
        `CFS_OFF_MASK:  next_mask = pwdata[`CFS_ST_W-1:0];
        `CFS_OFF_BUSTO: next_busto = pwdata[CNT_W-1:0];
        `CFS_OFF_TXTO:  next_txto = pwdata[CNT_W-1:0];
        `CFS_OFF_RXTO:  next_rxto = pwdata[CNT_W-1:0];
        default: next_mode = mode;
      endcase
    end
    if (rel_cmd) begin
      next_stat[`CFS_ST_TXRXSHORT] = 1'b0;
      next_stat[`CFS_ST_TXTIMEOUT] = 1'b0;
      if (~rxc_now) begin
        next_stat[`CFS_ST_RXCLAMP] = 1'b0;
      end
    end
    if (wr | rd) begin
      next_pready = 1'b1;
      next_pslverr = ~hit;
    end
    if (rd) begin
      case (paddr)
        `CFS_OFF_CTRL:  next_prdata = {28'h0000000, mode};
        `CFS_OFF_STAT:  next_prdata = {24'h000000, txblk, stat[`CFS_ST_W-2:0]};
        `CFS_OFF_MASK:  next_prdata = {24'h000000, mask};
        `CFS_OFF_BUSTO: next_prdata = 32'(busto);
        `CFS_OFF_TXTO:  next_prdata = 32'(txto);
        `CFS_OFF_RXTO:  next_prdata = 32'(rxto);
        `CFS_OFF_LINES: next_prdata = {26'h0, sense.line_fault};
        default:        next_prdata = 32'h0000_0000;
      endcase
    end
    // hardware sets win over software clears
    if (dom_evt) begin
      next_stat[`CFS_ST_DOMCLAMP] = 1'b1;
      if (mode == cfs_pkg::CFS_MODE_NORMAL) begin
        next_mode = cfs_pkg::CFS_MODE_RXONLY;
      end
    end
    if (sh_evt) next_stat[`CFS_ST_TXRXSHORT] = 1'b1;
    if (rxc_evt) next_stat[`CFS_ST_RXCLAMP] = 1'b1;
    if (txo_evt) next_stat[`CFS_ST_TXTIMEOUT] = 1'b1;
    if (|sense.line_fault) next_stat[`CFS_ST_BUSFAULT] = 1'b1;
    if (sense.overtemp) next_stat[`CFS_ST_OVERTEMP] = 1'b1;
    if (sense.undervoltage) next_stat[`CFS_ST_UNDERV] = 1'b1;
    next_stat[`CFS_ST_TXBLOCK] = 1'b0;
  end

  // ************************************
  // pin outputs
  // ************************************
  // ************************************
  // mode decode
  // ************************************
  always_comb begin
    mode_normal = 1'b0;
    mode_active = 1'b0;
    case (mode)
      cfs_pkg::CFS_MODE_OFF: begin
        mode_normal = 1'b0;
        mode_active = 1'b0;
      end
      cfs_pkg::CFS_MODE_WAKE: begin
        mode_normal = 1'b0;
        mode_active = 1'b0;
      end
      cfs_pkg::CFS_MODE_NORMAL: begin
        mode_normal = 1'b1;
        mode_active = 1'b1;
      end
      cfs_pkg::CFS_MODE_RXONLY: begin
        mode_normal = 1'b0;
        mode_active = 1'b1;
      end
      default: begin
        mode_normal = 1'b0;
        mode_active = 1'b0;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CFS_ST_W - 1; gi++) begin : g_irq
      assign irq_src[gi] = stat[gi] & ~mask[gi];
    end
  endgenerate

  always_comb begin
    next_drv_en = mode_normal & ~sense.overtemp & ~txblk;
    next_rxd = mode_active ? ~sense.rx_dominant : 1'b1;
    next_split_oe_n = ~mode_active;
    next_int_n = ~(|irq_src);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_cnt    <= '0;
      tx_cnt     <= '0;
      rx_cnt     <= '0;
      ot_wait    <= 1'b0;
      txd_q      <= 1'b1;
    end else begin
      bus_cnt    <= next_bus_cnt;
      tx_cnt     <= next_tx_cnt;
      rx_cnt     <= next_rx_cnt;
      ot_wait    <= next_ot_wait;
      txd_q      <= next_txd_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode       <= cfs_pkg::CFS_MODE_OFF;
      stat       <= '0;
      mask       <= `CFS_MASK_RESET;
      busto      <= CNT_W'(`CFS_BUSTO_RESET);
      txto       <= CNT_W'(`CFS_TXTO_RESET);
      rxto       <= CNT_W'(`CFS_RXTO_RESET);
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      mode       <= next_mode;
      stat       <= next_stat;
      mask       <= next_mask;
      busto      <= next_busto;
      txto       <= next_txto;
      rxto       <= next_rxto;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd        <= 1'b1;
      drv_en     <= 1'b0;
      split_oe_n <= 1'b1;
      int_n      <= 1'b1;
    end else begin
      rxd        <= next_rxd;
      drv_en     <= next_drv_en;
      split_oe_n <= next_split_oe_n;
      int_n      <= next_int_n;
    end
  end
endmodule

// ---- testbench/cfs_supervisor_properties.sv ----
// port checker of the fault supervisor
`timescale 1ns/1ps
module cfs_supervisor_properties (
  input wire logic                pclk, presetn, psel, penable, pready, pslverr,
  input wire logic                rxd_in, rxd, drv_en, split_oe_n,
  input wire cfs_pkg::cfs_sense_t sense
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_req; psel && penable && !pready; endsequence
  sequence s_hot; sense.overtemp [*3]; endsequence
  property p_wait; s_req |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("access not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hot; s_hot |-> !drv_en; endproperty
  a_hot: assert property (p_hot) else $error("driver on while hot");
  property p_rise; $rose(drv_en) |-> !$past(sense.overtemp); endproperty
  a_rise: assert property (p_rise) else $error("driver on during heat");
  property p_rx; (!split_oe_n && $stable(rxd_in)) [*3] |-> rxd == rxd_in; endproperty
  a_rx: assert property (p_rx) else $error("receive output wrong");
  property p_idle; split_oe_n [*3] |-> rxd; endproperty
  a_idle: assert property (p_idle) else $error("receive not idle");
endmodule
bind cfs_supervisor cfs_supervisor_properties u_cfs_supervisor_properties (.*);

// ---- testbench/cfs_bus_model.sv ----
// bus and host side model of the fault supervisor
`timescale 1ns/1ps
module cfs_bus_model (
  input  wire logic         txd, drv_en, dom, stuck, short_rx, ot, uv,
  input  wire logic [5:0]   lf,
  output cfs_pkg::cfs_sense_t sense,
  output logic              rxd_in
);
  logic bus_dom;
  assign bus_dom = (drv_en && !txd) || dom;
  // pin faults override the bus level
  assign rxd_in = stuck ? 1'b1 : (short_rx ? 1'b0 : !bus_dom);
  assign sense = '{bus_dom, !txd, !rxd_in, ot, uv, lf};
endmodule

// ---- testbench/can_transceiver_fault_supervisor_tb.sv ----
// self-checking bench of the fault supervisor
`timescale 1ns/1ps
`include "cfs_defs.svh"
module can_transceiver_fault_supervisor_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, txd = 1;
  logic dom = 0, stuck = 0, short_rx = 0, ot = 0, uv = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [5:0] lf = 0;
  logic pready, pslverr, rxd, rxd_in, drv_en, split_oe_n, int_n;
  cfs_pkg::cfs_sense_t sense;
  int miscompares = 0, n_tests = 0;
  cfs_supervisor u_cfs_supervisor (.*);
  cfs_bus_model u_cfs_bus_model (.*);
  initial forever #25 pclk = ~pclk;
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input string n, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task stat;
    apb(0, `CFS_OFF_STAT, 0);
  endtask
  task clr(input string n);
    apb(1, `CFS_OFF_STAT, 32'hff);
    $display("test %s done", n);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(11);
    chk("reset pins", {rxd, drv_en, split_oe_n, int_n}, 4'hb);
    cyc(1);
    presetn <= 1'b1;
    apb(0, `CFS_OFF_BUSTO, 0);
    chk("busto", rd, `CFS_BUSTO_RESET);
    apb(0, `CFS_OFF_MASK, 0);
    chk("mask", rd, `CFS_MASK_RESET);
    apb(0, 12'h01c, 0);
    chk("unmapped err", err, 1);
    chk("unmapped rd", rd, 0);
    apb(1, `CFS_OFF_BUSTO, 100);
    apb(1, `CFS_OFF_TXTO, 8);
    apb(1, `CFS_OFF_RXTO, 8);
    apb(1, `CFS_OFF_CTRL, 4);
    cyc(3);
    chk("normal", {drv_en, split_oe_n}, 2'b10);
    clr("registers");
    for (int i = 0; i < 6; i++) begin
      lf <= 6'h01 << i;
      cyc(3);
      chk("line int", int_n, 0);
      chk("line mode", drv_en, 1);
      apb(0, `CFS_OFF_LINES, 0);
      chk("lines", rd, 32'h1 << i);
      stat();
      chk("line stat", rd, 32'h10);
      lf <= 0;
      apb(1, `CFS_OFF_STAT, 32'hff);
    end
    apb(1, `CFS_OFF_MASK, 32'hff);
    lf <= 6'h20;
    uv <= 1;
    cyc(3);
    chk("masked", int_n, 1);
    stat();
    chk("uv stat", rd[6], 1);
    lf <= 0;
    uv <= 0;
    apb(1, `CFS_OFF_MASK, 0);
    clr("line faults");
    dom <= 1;
    cyc(60);
    dom <= 0;
    cyc(2);
    dom <= 1;
    cyc(60);
    chk("restart", drv_en, 1);
    cyc(50);
    chk("clamp", {drv_en, int_n}, 0);
    dom <= 0;
    stat();
    chk("clamp stat", rd[0], 1);
    chk("rxonly", {drv_en, split_oe_n, rxd}, 3'b001);
    apb(1, `CFS_OFF_CTRL, 4);
    cyc(3);
    chk("back", drv_en, 1);
    clr("clamp");
    ot <= 1;
    cyc(3);
    chk("hot", drv_en, 0);
    ot <= 0;
    cyc(5);
    chk("cool", {drv_en, split_oe_n}, 0);
    txd <= 0;
    cyc(2);
    txd <= 1;
    cyc(3);
    chk("edge", drv_en, 1);
    clr("overtemp");
    short_rx <= 1;
    cyc(4);
    chk("short", {drv_en, int_n}, 0);
    stat();
    chk("short stat", rd[1], 1);
    short_rx <= 0;
    cyc(3);
    chk("short hold", drv_en, 0);
    apb(1, `CFS_OFF_CTRL, 32'h1);
    cyc(2);
    chk("short off", {drv_en, split_oe_n}, 2'b01);
    apb(1, `CFS_OFF_CTRL, 32'h14);
    cyc(3);
    chk("short rel", drv_en, 1);
    clr("short");
    stuck <= 1;
    dom <= 1;
    cyc(20);
    apb(1, `CFS_OFF_CTRL, 32'h14);
    cyc(2);
    chk("rx clamp", drv_en, 0);
    stat();
    chk("rx stat", rd[2], 1);
    dom <= 0;
    stuck <= 0;
    cyc(3);
    chk("rx hold", drv_en, 0);
    apb(1, `CFS_OFF_CTRL, 32'h14);
    cyc(3);
    chk("rx rel", drv_en, 1);
    clr("rx clamp");
    txd <= 0;
    cyc(14);
    chk("tx to", drv_en, 0);
    stat();
    chk("tx stat", rd[3], 1);
    txd <= 1;
    apb(1, `CFS_OFF_CTRL, 32'h14);
    cyc(3);
    chk("tx rel", drv_en, 1);
    for (int k = 0; k < 5; k++) begin
      apb(1, `CFS_OFF_CTRL, k < 4 ? 32'h1 << k : 32'h3);
      cyc(3);
      chk("split", split_oe_n, k < 2);
    end
    chk("rxonly drv", drv_en, 0);
    clr("modes");
    summarize();
  end
  initial begin
    cyc(5000);
    miscompares++;
    summarize();
  end
endmodule
